// file: sfsfe_pkg.sv
// Purpose: shared constants and types for the serial flash spi front end
// Assumes: mclk at 250 MHz samples the serial pins
// Notes: Function
// Function
// [RL1] deselect: standby, serial output released
// [RL2] ignore serial input while deselected
// [RL3] select falls starts, rises ends operation
// [RL4] no standby until internal cycle finishes
// [RL5] sample input on serial clock rise
// [RL6] change output only on serial clock fall
// [RL7] accept mode 0 and mode 3
// [RL8] array of 32768 pages, 256/264 bytes
// [RL9] page size defaults to 264 bytes
// [RL10] two page buffers, fill during program
// [RL11] program and erase self-timed
// [RL12] opcode byte first, then address bytes
// [RL13] all fields most significant bit first
// [RL14] host sends three address bytes
// [RL15] counters cleared on select fall
// [RL16] select rise drops partial command
package sfsfe_pkg;
   localparam int unsigned sfsfe_pages = 32768;
   localparam int unsigned sfsfe_page_big = 264;
   localparam int unsigned sfsfe_page_small = 256;
   localparam int unsigned sfsfe_addr_bytes = 3;
   localparam logic [3:0] sfsfe_hdr_bytes = 4'h4;
   localparam logic [2:0] sfsfe_bit_last = 3'h7;
   localparam int unsigned sfsfe_fifo_depth = 8;
   localparam int unsigned sfsfe_byte_w = 8;
   localparam int unsigned sfsfe_mclk_mhz = 250;
   // internal program time, us; kept short here, a parameter of the top
   localparam int unsigned sfsfe_prog_us = 4000;
   localparam int unsigned sfsfe_prog_cycles = sfsfe_prog_us * sfsfe_mclk_mhz;
   typedef enum logic [1:0] {sfsfe_st_idle, sfsfe_st_op, sfsfe_st_hdr_done} sfsfe_ph_t;
endpackage

// file: sfsfe_fifo.sv
// Purpose: small valid/ready buffer for received data bytes
// Assumes: single clock, depth a power of two
// Notes: full and empty are exact; a full buffer drops in_ready and ignores the write
`timescale 1ns/1ps
module sfsfe_fifo #(
   parameter int unsigned width = 8,
   parameter int unsigned depth = 8
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // write side
   input wire logic [width-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // read side
   output logic [width-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int unsigned aw = $clog2(depth);
   typedef struct packed
   {
      logic [aw:0] wp;
      logic [aw:0] rp;
   } sfsfe_fptr_t;
   sfsfe_fptr_t st_reg, st_next;
   logic [width-1:0] mem [depth];
   logic full, empty;
   assign empty = st_reg.wp == st_reg.rp;
   assign full = (st_reg.wp[aw-1:0] == st_reg.rp[aw-1:0]) && (st_reg.wp[aw] != st_reg.rp[aw]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[st_reg.rp[aw-1:0]];
   always_comb
   begin
      st_next = st_reg;
      if (in_valid && !full)
      begin
         st_next.wp = st_reg.wp + 1'b1;
      end
      if (out_ready && !empty)
      begin
         st_next.rp = st_reg.rp + 1'b1;
      end
   end
   always_ff @(posedge mclk)
   begin
      if (in_valid && !full)
      begin
         mem[st_reg.wp[aw-1:0]] <= in_data;
      end
   end
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end
endmodule // sfsfe_fifo

// file: sfsfe_front.sv
// Purpose: spi slave front end of a serial flash: framing, shifting, standby
// Assumes: pins are asynchronous to mclk; serial clock well below mclk/4
// Notes: header bytes (opcode + address) go out as pulses, data bytes via fifo
`timescale 1ns/1ps
module sfsfe_front
   import sfsfe_pkg::*;
#(
   parameter int unsigned prog_cycles = sfsfe_prog_cycles
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // spi pins
   input wire logic cs_b,
   input wire logic sck,
   input wire logic si,
   output logic so_out,
   output logic so_oe,
   // configuration strap, low selects 256-byte pages
   input wire logic page_small_b,
   // header bytes to the command decoder
   output logic [7:0] hdr_byte,
   output logic [1:0] hdr_idx,
   output logic hdr_strobe,
   // data bytes to the page buffer
   output logic [7:0] wr_data,
   output logic wr_valid,
   input wire logic wr_ready,
   // read data from the core
   input wire logic [7:0] rd_byte,
   output logic rd_take,
   // internal cycle control
   input wire logic launch,
   output logic busy,
   output logic standby,
   output logic frame_end,
   output logic page_big
);
   typedef struct packed
   {
      logic [1:0] cs_s;
      logic [1:0] sck_s;
      logic [1:0] si_s;
      logic cs_d;
      logic sck_d;
      logic page_big;
      logic strap_done;
      logic [1:0] ps_s;
      logic [1:0] strap_age;
      sfsfe_ph_t ph;
      logic [2:0] bitc;
      logic [3:0] bytec;
      logic [7:0] sh;
      logic [7:0] osh;
      logic so_out;
      logic so_oe;
      logic [7:0] hdr_byte;
      logic [1:0] hdr_idx;
      logic hdr_strobe;
      logic [7:0] fdata;
      logic fvalid;
      logic rd_take;
      logic busy;
      logic [31:0] tmr;
      logic standby;
      logic frame_end;
      logic [7:0] wdata;
      logic wvalid;
   } sfsfe_fe_t;
   sfsfe_fe_t st_reg, st_next;
   logic f_ready;
   logic f_pop;
   logic f_wr_valid;
   logic [7:0] f_wr_data;
   sfsfe_fifo #(.width(sfsfe_byte_w), .depth(sfsfe_fifo_depth)) u_fifo (
      .mclk(mclk),
      .rst_b(rst_b),
      .in_data(st_reg.fdata),
      .in_valid(st_reg.fvalid),
      .in_ready(f_ready),
      .out_data(f_wr_data),
      .out_valid(f_wr_valid),
      .out_ready(f_pop)
   );
   always_comb
   begin
      logic sel, cs_fall, cs_rise, sck_rise, sck_fall;
      logic [7:0] nb;
      st_next = st_reg;
      st_next.cs_s = {st_reg.cs_s[0], cs_b};
      st_next.sck_s = {st_reg.sck_s[0], sck};
      st_next.si_s = {st_reg.si_s[0], si};
      st_next.cs_d = st_reg.cs_s[1];
      st_next.sck_d = st_reg.sck_s[1];
      sel = !st_reg.cs_s[1];
      cs_fall = st_reg.cs_d && !st_reg.cs_s[1];
      cs_rise = !st_reg.cs_d && st_reg.cs_s[1];
      // edges seen only while selected, so the idle level never matters
      sck_rise = sel && !st_reg.cs_d && !st_reg.sck_d && st_reg.sck_s[1]; // see [RL7]
      sck_fall = sel && !st_reg.cs_d && st_reg.sck_d && !st_reg.sck_s[1]; // see [RL7]
      nb = {st_reg.sh[6:0], st_reg.si_s[1]}; // see [RL13]
      st_next.hdr_strobe = 1'b0;
      st_next.rd_take = 1'b0;
      st_next.frame_end = 1'b0;
      st_next.ps_s = {st_reg.ps_s[0], page_small_b};
      // one-cycle offer: a byte that meets a full buffer is dropped, not held over
      st_next.fvalid = 1'b0;
      // registered output stage, so wr_data and wr_valid leave from flops
      if (wr_ready)
      begin
         st_next.wvalid = 1'b0;
      end
      if (f_wr_valid && f_pop)
      begin
         st_next.wvalid = 1'b1;
         st_next.wdata = f_wr_data; // see [RL10]
      end
      // strap caught once, after it has passed its synchroniser
      if (!st_reg.strap_done)
      begin
         st_next.strap_age = st_reg.strap_age + 2'h1;
         if (st_reg.strap_age[1])
         begin
            st_next.strap_done = 1'b1;
            st_next.page_big = st_reg.ps_s[1]; // see [RL9] [RL8]
         end
      end
      if (cs_fall)
      begin
         st_next.ph = sfsfe_st_op; // see [RL3]
         st_next.bitc = '0; // see [RL15]
         st_next.bytec = '0; // see [RL15]
         st_next.sh = '0;
         st_next.so_oe = 1'b1;
         st_next.standby = 1'b0;
      end
      if (sck_rise)
      begin
         st_next.sh = nb; // see [RL5] [RL2]
         st_next.bitc = st_reg.bitc + 3'h1;
         if (st_reg.bitc == sfsfe_bit_last)
         begin
            if (st_reg.bytec < sfsfe_hdr_bytes)
            begin
               // opcode at index 0, then three address bytes
               st_next.hdr_byte = nb; // see [RL12] [RL14]
               st_next.hdr_idx = st_reg.bytec[1:0];
               st_next.hdr_strobe = 1'b1;
               st_next.bytec = st_reg.bytec + 4'h1;
            end
            else
            begin
               // data continues to fill the buffer even while busy programming
               st_next.fdata = nb; // see [RL10]
               st_next.fvalid = 1'b1;
            end
         end
      end
      if (sck_fall)
      begin
         if (st_reg.bitc == '0)
         begin
            st_next.osh = {rd_byte[6:0], 1'b0};
            st_next.so_out = rd_byte[7]; // see [RL6] [RL13]
            st_next.rd_take = 1'b1;
         end
         else
         begin
            st_next.so_out = st_reg.osh[7]; // see [RL6]
            st_next.osh = {st_reg.osh[6:0], 1'b0};
         end
      end
      if (cs_rise || !sel)
      begin
         st_next.so_oe = 1'b0; // see [RL1]
         st_next.so_out = 1'b0;
      end
      if (cs_rise)
      begin
         // partial byte is dropped; decoder acts only if launch was given
         st_next.ph = sfsfe_st_idle; // see [RL16] [RL3]
         st_next.bitc = '0;
         st_next.frame_end = 1'b1;
      end
      if (launch && st_reg.ph != sfsfe_st_idle && !st_reg.busy)
      begin
         st_next.busy = 1'b1; // see [RL11]
         st_next.tmr = 32'(prog_cycles);
      end
      else if (st_reg.busy)
      begin
         if (st_reg.tmr <= 32'h1)
         begin
            st_next.busy = 1'b0;
         end
         st_next.tmr = st_reg.tmr - 32'h1; // see [RL11]
      end
      // standby deferred behind a running internal cycle
      st_next.standby = !sel && !st_next.busy && st_reg.ph == sfsfe_st_idle; // see [RL4] [RL1]
      case (st_reg.ph)
         sfsfe_st_idle: st_next.bytec = st_next.bytec;
         sfsfe_st_op: if (st_reg.bytec == sfsfe_hdr_bytes) st_next.ph = sfsfe_st_hdr_done;
         sfsfe_st_hdr_done: st_next.ph = st_next.ph;
         default: st_next.ph = sfsfe_st_idle;
      endcase
      if (cs_rise)
      begin
         st_next.ph = sfsfe_st_idle;
      end
   end
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_reg <= '{cs_s: 2'h3, cs_d: 1'b1, page_big: 1'b1, ps_s: 2'h3, ph: sfsfe_st_idle, standby: 1'b1,
            default: '0};
      end
      else
      begin
         st_reg <= st_next;
      end
   end
   assign so_out = st_reg.so_out;
   assign so_oe = st_reg.so_oe;
   assign hdr_byte = st_reg.hdr_byte;
   assign hdr_idx = st_reg.hdr_idx;
   assign hdr_strobe = st_reg.hdr_strobe;
   assign wr_data = st_reg.wdata;
   assign wr_valid = st_reg.wvalid;
   // the fifo drains whenever the output register is empty or being taken
   assign f_pop = !st_reg.wvalid || wr_ready;
   assign rd_take = st_reg.rd_take;
   assign busy = st_reg.busy;
   assign standby = st_reg.standby;
   assign frame_end = st_reg.frame_end;
   assign page_big = st_reg.page_big;
endmodule // sfsfe_front

// file: sfsfe_front_properties.sv
// Purpose: pin-level checks of the serial flash front end
// Assumes: sck holds each level at least 2 mclk
// Notes: latency bounds allow for the pin synchronisers
`timescale 1ns/1ps
module sfsfe_front_properties (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // spi pins
   input wire logic cs_b,
   input wire logic sck,
   input wire logic so_out,
   input wire logic so_oe,
   // core side
   input wire logic hdr_strobe,
   input wire logic rd_take,
   input wire logic busy,
   input wire logic standby,
   input wire logic frame_end
);
   logic [5:0] sck_h;
   always_ff @(posedge mclk)
   begin
      sck_h <= {sck_h[4:0], sck};
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   property p_oe_off; cs_b [*4] |-> !so_oe; endproperty
   a_oe_off: assert property (p_oe_off) else $error("so_oe high while deselected");
   property p_stby; (cs_b && !busy) [*8] |-> standby; endproperty
   a_stby: assert property (p_stby) else $error("no standby when idle");
   property p_no_stby; busy |-> !standby; endproperty
   a_no_stby: assert property (p_no_stby) else $error("standby while busy");
   property p_busy; $rose(busy) |-> busy [*8]; endproperty
   a_busy: assert property (p_busy) else $error("internal cycle too short");
   property p_desel; cs_b [*5] |-> !hdr_strobe && !rd_take; endproperty
   a_desel: assert property (p_desel) else $error("activity while deselected");
   // a change with sck high for six samples cannot follow a fall
   property p_so; $changed(so_out) && so_oe && $past(so_oe) |-> sck_h != 6'h3f; endproperty
   a_so: assert property (p_so) else $error("so_out moved without sck fall");
   property p_strobe; hdr_strobe |=> !hdr_strobe; endproperty
   a_strobe: assert property (p_strobe) else $error("header strobe too long");
   property p_end; $rose(cs_b) |-> ##[1:5] frame_end; endproperty
   a_end: assert property (p_end) else $error("no frame end");
   property p_start; $fell(cs_b) |-> ##[2:5] so_oe; endproperty
   a_start: assert property (p_start) else $error("no drive after select");
endmodule // sfsfe_front_properties
bind sfsfe_front sfsfe_front_properties chk (.mclk, .rst_b, .cs_b, .sck, .so_out, .so_oe, .hdr_strobe,
   .rd_take, .busy, .standby, .frame_end);

// file: sfsfe_host.sv
// Purpose: host spi master model for the front end pins
// Assumes: hp is the sck half period in mclk cycles
// Notes: so is not trusted while so_oe is low
`timescale 1ns/1ps
module sfsfe_host (
   // clock and pins from the device
   input wire logic mclk,
   input wire logic so_out,
   input wire logic so_oe,
   // pins to the device
   output logic cs_b,
   output logic sck,
   output logic si
);
   int hp = 4;
   logic m3 = 1'b0;
   // released line shows a moving pattern, never the last bit
   wire so = so_oe ? so_out : sck;
   task automatic wt(int n);
      repeat (n) @(posedge mclk);
   endtask
   // idle levels before the first frame
   task automatic park();
      cs_b <= 1'b1;
      sck <= 1'b0;
      si <= 1'b0;
   endtask
   task automatic sel(logic mode3);
      m3 = mode3;
      sck <= mode3;
      wt(hp);
      cs_b <= 1'b0;
      wt(hp);
   endtask
   task automatic bits(logic [7:0] tx, int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--)
      begin
         sck <= 1'b0;
         si <= tx[i];
         wt(hp);
         sck <= 1'b1;
         rx[i] = so;
         wt(hp);
      end
   endtask
   task automatic desel();
      if (!m3) sck <= 1'b0;
      wt(hp);
      cs_b <= 1'b1;
      wt(4 * hp);
   endtask
   task automatic junk(int n);
      for (int i = 0; i < n; i++)
      begin
         si <= ~si;
         sck <= ~sck;
         wt(hp);
      end
   endtask
endmodule // sfsfe_host

// file: tb_top.sv
// Purpose: self-checking bench of the serial flash front end
// Assumes: prog_cycles shortened to 60, link clock 32 ns
// Notes: header and data bytes are collected and compared in order
`timescale 1ns/1ps
module tb_top;
   import sfsfe_pkg::*;
   logic mclk, rst_b, page_small_b, wr_ready, launch, hold;
   logic [7:0] rd_byte, rx, hdr_byte, wr_data;
   logic cs_b, sck, si, so_out, so_oe, hdr_strobe, wr_valid, rd_take, busy, standby, frame_end, page_big;
   logic [1:0] hdr_idx;
   logic [10:0] eq[$], sq[$];
   logic [31:0] seed = 32'hf0bf9ac9;
   int err_count = 0, cmp_count = 0;
   sfsfe_front #(.prog_cycles(60)) dut (.mclk, .rst_b, .cs_b, .sck, .si, .so_out, .so_oe, .page_small_b,
      .hdr_byte, .hdr_idx, .hdr_strobe, .wr_data, .wr_valid, .wr_ready, .rd_byte, .rd_take, .launch, .busy,
      .standby, .frame_end, .page_big);
   sfsfe_host host (.mclk, .so_out, .so_oe, .cs_b, .sck, .si);
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   always @(posedge mclk)
   begin
      if (hdr_strobe === 1'b1) sq.push_back({1'b0, hdr_idx, hdr_byte});
      if (wr_valid === 1'b1 && wr_ready === 1'b1) sq.push_back({3'h4, wr_data});
      wr_ready <= hold ? 1'b0 : ^xs();
   end
   task automatic chk(string n, logic [10:0] e, logic [10:0] s);
      cmp_count++;
      if (e !== s)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic frame(logic m3, int nh, int nd, int pb, logic go);
      logic [7:0] b;
      host.sel(m3);
      for (int i = 0; i < nh + nd; i++)
      begin
         b = 8'(xs());
         // a stalled path keeps its buffer depth plus the output register; later bytes drop
         if (i < nh + (hold ? sfsfe_fifo_depth + 1 : nd)) eq.push_back(i < nh ? {1'b0, 2'(i), b} : {3'h4, b});
         host.bits(b, 8, rx);
      end
      chk("so", {3'h0, rd_byte}, {3'h0, rx});
      if (go) launch <= 1'b1;
      host.wt(1);
      launch <= 1'b0;
      b = 8'(xs());
      if (pb > 0) host.bits(b, pb, rx);
      host.desel();
      hold <= 1'b0;
      for (int w = 0; w < 400 && sq.size() < eq.size(); w++) @(posedge mclk);
      host.wt(8);
      chk("count", 11'(eq.size()), 11'(sq.size()));
      while (eq.size() > 0 && sq.size() > 0) chk("byte", eq.pop_front(), sq.pop_front());
      chk("empty", 11'h0, {10'h0, wr_valid});
      eq.delete();
      sq.delete();
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      // the whole run needs some 12,000 mclk; this allows over four times that
      #200000;
      err_count++;
      wrap_up();
   end
   initial
   begin
      rst_b = 1'b0;
      page_small_b = 1'b1;
      launch = 1'b0;
      hold = 1'b0;
      rd_byte = 8'h00;
      host.park();
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      // the strap passes two flops before it is caught
      host.wt(5);
      chk("page_big", 11'h1, {10'h0, page_big});
      chk("standby", 11'h1, {10'h0, standby});
      for (int t = 0; t < 24; t++)
      begin
         rd_byte <= 8'(xs());
         frame(t[0], 4, t % 4, 0, 1'b0);
      end
      $display("test random frames done");
      frame(1'b1, 2, 0, 5, 1'b0);
      frame(1'b0, 4, 1, 3, 1'b0);
      host.junk(40);
      host.wt(8);
      chk("idle", 11'h0, 11'(sq.size()));
      $display("test partial and idle done");
      hold <= 1'b1;
      frame(1'b0, 4, 10, 0, 1'b0);
      $display("test stalled buffer done");
      frame(1'b1, 1, 0, 0, 1'b1);
      chk("busy", 11'h1, {10'h0, busy});
      chk("standby", 11'h0, {10'h0, standby});
      for (int w = 0; w < 100 && standby !== 1'b1; w++) @(posedge mclk);
      chk("standby", 11'h1, {10'h0, standby});
      $display("test internal cycle done");
      rst_b <= 1'b0;
      page_small_b <= 1'b0;
      host.wt(12);
      rst_b <= 1'b1;
      host.wt(5);
      chk("page_big", 11'h0, {10'h0, page_big});
      frame(1'b0, 4, 2, 0, 1'b0);
      $display("test small page done");
      wrap_up();
   end
endmodule // tb_top
